// ===== src/cce_condition_evaluator.sv
`timescale 1ns/1ps
`include "cce_params.svh"
// Functional notes
// [RQ1] Selector 00 branch pin low, 01 test flag set, 10 clear, 11 none.
// [RQ2] Low four condition bits form the mask of flag conditions tested.
// [RQ3] Only conditions with mask bit one are tested; cleared bits are ignored.
// [RQ4] Bits four to seven give the wanted state of each tested condition.
// [RQ5] Flag bits in order: sum zero, sum negative, overflow, carry.
// [RQ6] Zero and negative masked, others clear, gives greater-or-equal zero test.
// [RQ7] Mask ANDed with state match; any set result bit means condition met.
// [RQ8] Two-word opcodes fetch a 16-bit second word as constant or address.
// [RQ9] Sum register read as upper bits 31-16 and lower bits 15-0.
// [RQ10] Loading the aux pointer keeps its previous value in the prior copy.
// [RQ11] A named next aux register 0-7 becomes the pointer when complete.
// [RQ12] Short direct operand is the seven low bits of a data address.
// [RQ13] Selector is a two-bit field of conditional opcodes.
// [RQ14] Count bit zero runs one following instruction, one runs two.
// [RQ15] Overall condition met only when selector and flag tests both pass.
// [RQ16] Flag tests use flags of the latest completed sum update.
module cce_condition_evaluator
    import cce_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Device pins and status
    input  wire logic        branchInputPin,
    output logic             conditionMet,
    output logic      [1:0]  runLength,
    output logic             secondPending
);

    // ****************************************
    // Bus slave
    // ****************************************
    // Zero wait states; a read is sampled in its address phase, so a read that
    // directly follows a write to the same register returns the older value.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic       takeXfer;
    logic       wrPend;
    logic [7:0] wrAddr;
    logic       wrStrobe;

    assign takeXfer = hsel & htrans[1] & hready;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else begin
            wrPend <= takeXfer & hwrite;
            if (takeXfer) begin
                wrAddr <= haddr[7:0];
            end
        end
    end

    assign wrStrobe = wrPend;

    function automatic logic hitReg(input logic [7:0] a, input logic [7:0] ofs);
        return (a == ofs);
    endfunction

    // ****************************************
    // Architectural state
    // ****************************************
    cce_state_t  state;
    logic [31:0] opcodeReg;
    cce_word_t   secondWord;
    logic [31:0] sumRegister;
    logic        overflowFlag;
    logic        carryFlag;
    logic        testFlag;
    cce_aux_t    auxPointer;
    cce_aux_t    priorPointerCopy;
    logic [6:0]  directOffset;
    logic [8:0]  directPage;
    logic        pinOkReg;
    logic        flagOkReg;
    logic        completeSeen;
    logic        pinLevel;

    // ****************************************
    // Opcode decode
    // ****************************************
    cce_nib_t maskField;
    cce_nib_t stateField;
    cce_sel_t pinFlagSelector;
    logic     runTwo;
    logic     twoWord;
    cce_aux_t nextAuxSelect;
    logic     nextAuxEnable;

    assign maskField       = opcodeReg[`CCE_OP_MASK_LSB +: 4];   // see [RQ2]
    assign stateField      = opcodeReg[`CCE_OP_STATE_LSB +: 4];  // see [RQ4]
    assign pinFlagSelector = opcodeReg[`CCE_OP_SEL_LSB +: 2];    // see [RQ13]
    assign runTwo          = opcodeReg[`CCE_OP_RUN_BIT];
    assign twoWord         = opcodeReg[`CCE_OP_TWO_BIT];
    assign nextAuxSelect   = opcodeReg[`CCE_OP_AUX_LSB +: 3];
    assign nextAuxEnable   = opcodeReg[`CCE_OP_AUXEN_BIT];

    // ****************************************
    // Flag gathering
    // ****************************************
    // Zero and negative follow the sum register itself, so they always reflect
    // the latest completed write to it.
    cce_nib_t flagTestFields;
    logic     sumZero;
    logic     sumNegative;

    assign sumZero     = (sumRegister == `CCE_RST_WORD);      // see [RQ16]
    assign sumNegative = sumRegister[31];                     // see [RQ16]

    always_comb begin
        flagTestFields                 = 4'h0;
        flagTestFields[`CCE_FT_ZERO]   = sumZero;             // see [RQ5]
        flagTestFields[`CCE_FT_NEG]    = sumNegative;         // see [RQ5]
        flagTestFields[`CCE_FT_OVF]    = overflowFlag;        // see [RQ5]
        flagTestFields[`CCE_FT_CARRY]  = carryFlag;           // see [RQ5]
    end

    // ****************************************
    // Evaluation
    // ****************************************
    logic pinOk;
    logic flagOk;

    cce_pin_sync u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .pinIn    (branchInputPin),
        .pinLevel (pinLevel)
    );

    cce_flag_eval u_eval (
        .selector (pinFlagSelector),
        .mask     (maskField),
        .wanted   (stateField),
        .pinLevel (pinLevel),
        .testFlag (testFlag),
        .flags    (flagTestFields),
        .pinOk    (pinOk),
        .flagOk   (flagOk)
    );

    // ****************************************
    // Instruction sequencing
    // ****************************************
    logic opcodeWrite;
    logic secondWrite;
    logic complete;

    assign opcodeWrite = wrStrobe & hitReg(wrAddr, `CCE_OFS_OPCODE);
    assign secondWrite = wrStrobe & hitReg(wrAddr, `CCE_OFS_SECOND);
    // One-word opcodes finish the cycle after their write; two-word ones wait
    assign complete = ((state == CCE_IDLE) & completeSeen) |
                      ((state == CCE_WAIT_SECOND) & secondWrite);   // see [RQ8]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            opcodeReg <= `CCE_RST_WORD;
        end else if (opcodeWrite) begin
            opcodeReg <= {16'h0000, hwdata[15:0]};
        end
    end

    // A fresh opcode write aborts any second-word wait
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state        <= CCE_IDLE;
            completeSeen <= 1'b0;
        end else begin
            completeSeen <= opcodeWrite & ~hwdata[`CCE_OP_TWO_BIT];
            if (opcodeWrite) begin
                state <= hwdata[`CCE_OP_TWO_BIT] ? CCE_WAIT_SECOND : CCE_IDLE;
            end else if (secondWrite) begin
                state <= CCE_IDLE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            secondWord <= 16'h0000;
        end else if (secondWrite & (state == CCE_WAIT_SECOND)) begin
            secondWord <= hwdata[15:0];                      // see [RQ8]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            conditionMet <= 1'b0;
            pinOkReg     <= 1'b0;
            flagOkReg    <= 1'b0;
            runLength    <= 2'h0;
        end else if (complete) begin
            conditionMet <= pinOk & flagOk;                  // see [RQ15]
            pinOkReg     <= pinOk;
            flagOkReg    <= flagOk;
            runLength    <= runTwo ? 2'h2 : 2'h1;            // see [RQ14]
        end
    end

    assign secondPending = (state == CCE_WAIT_SECOND);

    // ****************************************
    // Sum register and flags
    // ****************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sumRegister <= `CCE_RST_WORD;
        end else if (wrStrobe & hitReg(wrAddr, `CCE_OFS_SUM)) begin
            sumRegister <= hwdata;
        end else if (wrStrobe & hitReg(wrAddr, `CCE_OFS_SUMHI)) begin
            sumRegister[31:16] <= hwdata[15:0];              // see [RQ9]
        end else if (wrStrobe & hitReg(wrAddr, `CCE_OFS_SUMLO)) begin
            sumRegister[15:0] <= hwdata[15:0];               // see [RQ9]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            overflowFlag <= 1'b0;
            carryFlag    <= 1'b0;
            testFlag     <= 1'b0;
        end else if (wrStrobe & hitReg(wrAddr, `CCE_OFS_FLAGS)) begin
            overflowFlag <= hwdata[`CCE_FL_OVF];
            carryFlag    <= hwdata[`CCE_FL_CARRY];
            testFlag     <= hwdata[`CCE_FL_TEST];
        end
    end

    // ****************************************
    // Auxiliary pointer
    // ****************************************
    // A software load and an instruction completion in the same cycle: the
    // completing instruction wins, as it is the later architectural event.
    logic     auxLoad;
    cce_aux_t auxNew;

    always_comb begin
        auxLoad = 1'b0;
        auxNew  = auxPointer;
        if (complete & nextAuxEnable) begin
            auxLoad = 1'b1;
            auxNew  = nextAuxSelect;                         // see [RQ11]
        end else if (wrStrobe & hitReg(wrAddr, `CCE_OFS_AUXPTR)) begin
            auxLoad = 1'b1;
            auxNew  = hwdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            auxPointer       <= `CCE_RST_AUX;
            priorPointerCopy <= `CCE_RST_AUX;
        end else if (auxLoad) begin
            auxPointer       <= auxNew;
            priorPointerCopy <= auxPointer;                  // see [RQ10]
        end
    end

    // ****************************************
    // Short direct address
    // ****************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            directOffset <= 7'h00;
            directPage   <= 9'h000;
        end else if (wrStrobe & hitReg(wrAddr, `CCE_OFS_DIRECT)) begin
            directOffset <= hwdata[`CCE_DMA_BITS-1:0];       // see [RQ12]
            directPage   <= hwdata[`CCE_PAGE_LSB +: 9];
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] next_hrdata;

    always_comb begin
        next_hrdata = 32'h0000_0000;
        unique case (haddr[7:0])
            `CCE_OFS_OPCODE: next_hrdata = opcodeReg;
            `CCE_OFS_SECOND: next_hrdata = {16'h0000, secondWord};
            `CCE_OFS_SUM:    next_hrdata = sumRegister;
            `CCE_OFS_SUMHI:  next_hrdata = {16'h0000, sumRegister[31:16]};  // see [RQ9]
            `CCE_OFS_SUMLO:  next_hrdata = {16'h0000, sumRegister[15:0]};   // see [RQ9]
            `CCE_OFS_FLAGS:  next_hrdata = {27'h000_0000, sumNegative, sumZero,
                                            testFlag, carryFlag, overflowFlag};
            `CCE_OFS_AUXPTR: next_hrdata = {25'h000_0000, priorPointerCopy,
                                            1'b0, auxPointer};
            `CCE_OFS_RESULT: next_hrdata = {25'h000_0000, pinLevel, runLength,
                                            secondPending, flagOkReg, pinOkReg,
                                            conditionMet};
            `CCE_OFS_DIRECT: next_hrdata = {16'h0000, directPage, directOffset};
            default:         next_hrdata = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h00_0000) begin
            next_hrdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (takeXfer & ~hwrite) begin
            hrdata <= next_hrdata;
        end
    end

endmodule

// ===== src/cce_params.svh
`ifndef CCE_PARAMS_SVH
`define CCE_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CCE_OFS_OPCODE   8'h00
`define CCE_OFS_SECOND   8'h04
`define CCE_OFS_SUM      8'h08
`define CCE_OFS_SUMHI    8'h0C
`define CCE_OFS_SUMLO    8'h10
`define CCE_OFS_FLAGS    8'h14
`define CCE_OFS_AUXPTR   8'h18
`define CCE_OFS_RESULT   8'h1C
`define CCE_OFS_DIRECT   8'h20

// ****************************************
// Opcode register fields
// ****************************************
`define CCE_OP_MASK_LSB  0
`define CCE_OP_STATE_LSB 4
`define CCE_OP_SEL_LSB   8
`define CCE_OP_RUN_BIT   10
`define CCE_OP_TWO_BIT   11
`define CCE_OP_AUX_LSB   12
`define CCE_OP_AUXEN_BIT 15

// ****************************************
// Flag test bit positions
// ****************************************
`define CCE_FT_ZERO      0
`define CCE_FT_NEG       1
`define CCE_FT_OVF       2
`define CCE_FT_CARRY     3

// ****************************************
// Flags, pointer and direct address fields
// ****************************************
`define CCE_FL_OVF       0
`define CCE_FL_CARRY     1
`define CCE_FL_TEST      2
`define CCE_FL_ZERO      3
`define CCE_FL_NEG       4
`define CCE_AUX_PRIOR    4
`define CCE_DMA_BITS     7
`define CCE_PAGE_LSB     16

// ****************************************
// Reset values
// ****************************************
`define CCE_RST_WORD     32'h0000_0000
`define CCE_RST_AUX      3'h0

`endif

// ===== src/cce_pkg.sv
package cce_pkg;

    typedef logic [1:0]  cce_sel_t;
    typedef logic [3:0]  cce_nib_t;
    typedef logic [2:0]  cce_aux_t;
    typedef logic [15:0] cce_word_t;

    typedef enum logic {
        CCE_IDLE,
        CCE_WAIT_SECOND
    } cce_state_t;

endpackage

// ===== src/cce_pin_sync.sv
`timescale 1ns/1ps
module cce_pin_sync
    import cce_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Pin and filtered level
    input  wire logic pinIn,
    output logic      pinLevel
);

    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Stage one is never looked at; a change is taken once two and three agree
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pinLevel <= 1'b1;
        end else if (stage2 == stage3) begin
            pinLevel <= stage3;
        end
    end

endmodule

// ===== src/cce_flag_eval.sv
`timescale 1ns/1ps
`include "cce_params.svh"
module cce_flag_eval
    import cce_pkg::*;
(
    // Decoded condition
    input  wire cce_sel_t selector,
    input  wire cce_nib_t mask,
    input  wire cce_nib_t wanted,
    // Live state
    input  wire logic     pinLevel,
    input  wire logic     testFlag,
    input  wire cce_nib_t flags,
    // Verdicts
    output logic          pinOk,
    output logic          flagOk
);

    function automatic logic pinTest(input cce_sel_t s, input logic pin, input logic tf);
        logic r;
        r = 1'b1;
        unique case (s)
            2'b00: r = ~pin;  // see [RQ1]
            2'b01: r = tf;    // see [RQ1]
            2'b10: r = ~tf;   // see [RQ1]
            2'b11: r = 1'b1;  // see [RQ1]
        endcase
        return r;
    endfunction

    logic [3:0] hits;

    always_comb begin
        pinOk = pinTest(selector, pinLevel, testFlag);
        // Masked-off bits drop out; a set mask bit hits when the flag has the wanted state
        hits = mask & ~(wanted ^ flags);           // see [RQ3] see [RQ7]
        // Empty mask tests nothing, so the flag side passes
        flagOk = (mask == 4'h0) | (|hits);         // see [RQ3] see [RQ6] see [RQ7]
    end

endmodule

// ===== bench/cce_condition_evaluator_chk.sv
`timescale 1ns/1ps
`include "cce_params.svh"
module cce_condition_evaluator_chk
    import cce_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pin and status
    input wire logic        branchInputPin,
    input wire logic        conditionMet,
    input wire logic [1:0]  runLength,
    input wire logic        secondPending
);
    // ********
    // Data phase tracking
    // ********
    logic        dataWr;
    logic        dataRd;
    logic [31:0] dataAddr;
    wire         opcWr = dataWr && dataAddr == 32'h0000_0000;
    wire         secWr = dataWr && dataAddr == 32'h0000_0004;
    // Selector 00, no flag mask, one word, count zero
    wire         freeSel0 = opcWr && hwdata[11:8] == 4'h0 && hwdata[3:0] == 4'h0;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dataWr <= 1'b0;
            dataRd <= 1'b0;
            dataAddr <= 32'h0000_0000;
        end else if (hready) begin
            dataWr <= hsel && htrans[1] && hwrite;
            dataRd <= hsel && htrans[1] && !hwrite;
            dataAddr <= haddr;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // ********
    // Named steps
    // ********
    sequence oneWordOp;
        opcWr && !hwdata[`CCE_OP_TWO_BIT];
    endsequence
    // Eight quiet cycles let the pin filter settle before the opcode lands
    sequence pinLowHeld;
        (!branchInputPin) [*8] ##0 freeSel0;
    endsequence
    sequence pinHighHeld;
        branchInputPin [*8] ##0 freeSel0;
    endsequence

    // ********
    // Assertions
    // ********
    okay_resp_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    rst_vals_a: assert property ($rose(resetn) |->
        !conditionMet && runLength == 2'd0 && !secondPending && hrdata == 32'h0000_0000)
        else $error("outputs not at reset values");
    pend_start_a: assert property (opcWr && hwdata[`CCE_OP_TWO_BIT] |=> secondPending)
        else $error("second word not awaited");
    pend_hold_a: assert property (secondPending && !opcWr && !secWr |=> secondPending)
        else $error("second word wait dropped");
    pend_end_a: assert property (secWr && secondPending |=> !secondPending)
        else $error("second word did not complete");
    run_len_a: assert property (oneWordOp |->
        ##2 runLength == ($past(hwdata[`CCE_OP_RUN_BIT], 2) ? 2'd2 : 2'd1))
        else $error("run length wrong");
    none_met_a: assert property (oneWordOp ##0 (hwdata[9:8] == 2'b11 && hwdata[3:0] == 4'h0)
        |-> ##2 conditionMet)
        else $error("unconditional test not met");
    pin_low_a: assert property (pinLowHeld |-> ##2 conditionMet)
        else $error("low pin not met");
    pin_high_a: assert property (pinHighHeld |-> ##2 !conditionMet)
        else $error("high pin met");
    unmap_rd_a: assert property (dataRd && dataAddr > 32'h0000_0020 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind cce_condition_evaluator cce_condition_evaluator_chk u_chk (
    .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .branchInputPin, .conditionMet, .runLength,
    .secondPending
);

// ===== bench/cce_condition_evaluator_test.sv
`timescale 1ns/1ps
`include "cce_params.svh"
module cce_condition_evaluator_test
    import cce_pkg::*;
;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        branchInputPin = 1'b1;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        conditionMet;
    logic [1:0]  runLength;
    logic        secondPending;
    int          failures = 0;
    int          check_count = 0;

    always #2 clk = ~clk;

    cce_condition_evaluator DUT (
        .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .branchInputPin,
        .conditionMet, .runLength, .secondPending
    );

    // ********
    // Bus and compare helpers
    // ********
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0000_0000, q);
        chk(what, q, exp);
    endtask

    // Idle cycle: a read taken at the completion edge would still see the old verdict
    task automatic run(input logic [15:0] op, output logic [31:0] res);
        wr(`CCE_OFS_OPCODE, {16'h0000, op});
        @(posedge clk);
        xfer(`CCE_OFS_RESULT, 1'b0, 32'h0000_0000, res);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        rdc("opcode", `CCE_OFS_OPCODE, 32'h0000_0000);
        rdc("sum", `CCE_OFS_SUM, 32'h0000_0000);
        rdc("auxptr", `CCE_OFS_AUXPTR, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rdc("unmapped", 8'h40, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_sum;
        wr(`CCE_OFS_SUM, 32'h8765_4321);
        rdc("sum hi", `CCE_OFS_SUMHI, 32'h0000_8765);
        rdc("sum lo", `CCE_OFS_SUMLO, 32'h0000_4321);
        wr(`CCE_OFS_SUMLO, 32'h0000_BEEF);
        rdc("sum", `CCE_OFS_SUM, 32'h8765_BEEF);
        rdc("neg flag", `CCE_OFS_FLAGS, 32'h0000_0010);
        wr(`CCE_OFS_SUM, 32'h0000_0000);
        rdc("zero flag", `CCE_OFS_FLAGS, 32'h0000_0008);
        $display("test sum done");
    endtask

    task automatic t_flags;
        logic [3:0]  fl [4] = '{4'b0001, 4'b0010, 4'b1100, 4'b1010};
        logic [7:0]  cb [11] = '{8'h00, 8'h01, 8'h11, 8'h02, 8'h22, 8'h04, 8'h44,
                                 8'h08, 8'h88, 8'h13, 8'hF0};
        logic [3:0]  f;
        logic [3:0]  m;
        logic [31:0] r;
        logic        e;
        foreach (fl[i]) begin
            f = fl[i];
            wr(`CCE_OFS_SUM, f[0] ? 32'h0 : (f[1] ? 32'h8000_0000 : 32'h0000_0001));
            wr(`CCE_OFS_FLAGS, {29'h0, 1'b0, f[3], f[2]});
            foreach (cb[j]) begin
                m = cb[j][3:0];
                // Met when nothing is masked or one masked flag has its wanted state
                e = (m == 4'h0);
                for (int k = 0; k < 4; k++) begin
                    if (m[k] && (f[k] == cb[j][4 + k])) begin
                        e = 1'b1;
                    end
                end
                run({8'h03, cb[j]}, r);
                chk("flag met", 32'(r[0]), 32'(e));
                chk("flag ok", 32'(r[2]), 32'(e));
                chk("met pin", 32'(conditionMet), 32'(e));
            end
        end
        // Greater-or-equal-zero test: zero and negative masked, zero wanted set
        wr(`CCE_OFS_SUM, 32'h8000_0000);
        run(16'h0313, r);
        chk("ge zero neg", 32'(r[0]), 32'h0000_0000);
        wr(`CCE_OFS_SUM, 32'h0000_0007);
        run(16'h0313, r);
        chk("ge zero pos", 32'(r[0]), 32'h0000_0001);
        $display("test flags done");
    endtask

    task automatic t_sel;
        logic [31:0] r;
        logic        e;
        logic        n;
        for (int p = 0; p < 2; p++) begin
            for (int t = 0; t < 2; t++) begin
                for (int s = 0; s < 4; s++) begin
                    n = s[0] ^ p[0];
                    branchInputPin <= p[0];
                    wr(`CCE_OFS_FLAGS, {29'h0, t[0], 2'b00});
                    repeat (8) @(posedge clk);
                    run({5'h00, n, 2'(s), 8'h00}, r);
                    e = (s == 0) ? (p == 0) : (s == 1) ? (t == 1) : (s == 2) ? (t == 0) : 1'b1;
                    chk("sel met", 32'(r[0]), 32'(e));
                    chk("run length", 32'(runLength), n ? 32'd2 : 32'd1);
                end
            end
        end
        $display("test selector done");
    endtask

    task automatic t_two;
        wr(`CCE_OFS_OPCODE, 32'h0000_0800);
        @(posedge clk);
        chk("pending", 32'(secondPending), 32'h1);
        wr(`CCE_OFS_SECOND, 32'h0000_1234);
        @(posedge clk);
        chk("pending", 32'(secondPending), 32'h0);
        rdc("second", `CCE_OFS_SECOND, 32'h0000_1234);
        wr(`CCE_OFS_SECOND, 32'h0000_5555);
        rdc("second", `CCE_OFS_SECOND, 32'h0000_1234);
        wr(`CCE_OFS_OPCODE, 32'h0000_0800);
        wr(`CCE_OFS_OPCODE, 32'h0000_0300);
        @(posedge clk);
        chk("abort", 32'(secondPending), 32'h0);
        $display("test two word done");
    endtask

    task automatic t_aux;
        logic [31:0] r;
        logic [2:0]  prev;
        wr(`CCE_OFS_AUXPTR, 32'h0000_0005);
        rdc("aux", `CCE_OFS_AUXPTR, 32'h0000_0005);
        prev = 3'h5;
        for (int n = 0; n < 8; n++) begin
            run({1'b1, 3'(n), 12'h300}, r);
            rdc("aux", `CCE_OFS_AUXPTR, {25'h0, prev, 1'b0, 3'(n)});
            prev = 3'(n);
        end
        $display("test aux done");
    endtask

    task automatic t_direct;
        wr(`CCE_OFS_DIRECT, 32'h0123_00FF);
        rdc("direct", `CCE_OFS_DIRECT, 32'h0000_91FF);
        $display("test direct done");
    endtask

    // ********
    // Run control
    // ********
    task automatic print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // All scenarios need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_sum();
        t_flags();
        t_sel();
        t_two();
        t_aux();
        t_direct();
        print_verdict();
    end
endmodule
